// ==== emc_pkg.sv ====
package emc_pkg;
  localparam logic [11:0] EMC_OFS_CTRL = 12'h000;
  localparam logic [11:0] EMC_OFS_RAMPWR = 12'h004;
  localparam logic [11:0] EMC_OFS_LOCK = 12'h008;
  localparam logic [11:0] EMC_OFS_AUX = 12'h024;
  localparam logic [11:0] EMC_OFS_STATUS = 12'h030;
  localparam int EMC_CTRL_DRIVE_BIT = 0;
  localparam int EMC_CTRL_BLOCK_BIT = 1;
  localparam int EMC_CTRL_SEQ_LSB = 2;
  localparam logic [1:0] EMC_SEQ_A = 2'h2;
  localparam logic [1:0] EMC_SEQ_B = 2'h3;
  localparam logic [3:0] EMC_SEQ_LAST = 4'h8;
  localparam logic [2:0] EMC_PD_BLK3 = 3'h4;
  localparam logic [2:0] EMC_PD_BLK23 = 3'h6;
  localparam logic [2:0] EMC_PD_BLK123 = 3'h7;
  localparam logic [31:0] EMC_CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] EMC_LOCK_RESET = 16'h0000;
  localparam int EMC_SRC_W = 17;
  // Wake source bit positions
  localparam int EMC_W_RTC = 0;
  localparam int EMC_W_USART = 1;
  localparam int EMC_W_UART = 2;
  localparam int EMC_W_LOW_ENERGY_UART = 3;
  localparam int EMC_W_I2C = 4;
  localparam int EMC_W_I2C_ADDR = 5;
  localparam int EMC_W_TIMER = 6;
  localparam int EMC_W_LOW_ENERGY_TIMER = 7;
  localparam int EMC_W_CLK = 8;
  localparam int EMC_W_DMA = 9;
  localparam int EMC_W_FLASH = 10;
  localparam int EMC_W_DAC = 11;
  localparam int EMC_W_ADC = 12;
  localparam int EMC_W_AES = 13;
  localparam int EMC_W_PULSE_COUNTER = 14;
  localparam int EMC_W_LCD = 15;
  localparam int EMC_W_CMP = 16;
  typedef enum logic [2:0] {
    EMC_ACTIVE = 3'b000,
    EMC_LIGHT = 3'b001,
    EMC_DEEP = 3'b010,
    EMC_STOP = 3'b011,
    EMC_SHUTOFF = 3'b100
  } emc_mode_t;
endpackage

// ==== emc_energy_mode_wakeup_control.sv ====
// Notes on behaviour
// RULE_01: Every wakeup returns straight to active mode.
// RULE_02: Any reset leaves chip in active mode.
// RULE_03: Light sleep wakes on any enabled peripheral.
// RULE_04: Deep sleep wakes only on low-energy peripherals.
// RULE_05: Address, comparator, pin wake light/deep/stop.
// RULE_06: Stop wakes on pulse counter only externally clocked.
// RULE_07: Shutoff ignores all interrupts; reset only.
// RULE_08: Software powers down selected SRAM blocks.
// RULE_09: Powered-down block stays off until reset.
// RULE_10: First SRAM block is never powered down.
// RULE_11: Entry field bits 3:2, reset zero, enters shutoff.
// RULE_12: Block bit refuses deep sleep or lower; code blocks deep only, shutoff sequence still enters shutoff.
// RULE_13: Drive bit: zero reduced, one full.
// RULE_14: Reserved control bits written zero, ignored.
// RULE_15: Shutoff sequence is 2,3,2,3,2,3,2,3,2.
// RULE_16: Writing zero restarts sequence tracking.
// RULE_17: Blocked deep request falls to light sleep.
// RULE_18: Codes 4, 6, 7 power off blocks 3, 2-3, 1-3.
// RULE_19: Wrong sequence value abandons partial sequence.
module emc_energy_mode_wakeup_control
  import emc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core sleep request
  input wire logic sleep_req,
  input wire logic sleep_deep,
  // Wakeup sources, enabled and gated by each peripheral
  input wire logic [emc_pkg::EMC_SRC_W-1:0] wake_src,
  input wire logic pulse_counter_ext_clk,
  input wire logic pin_irq,
  // Power and clock controls
  output emc_pkg::emc_mode_t mode,
  output logic reg_full_drive,
  output logic [3:0] ram_block_on
);
  import emc_pkg::*;

  emc_mode_t mode_reg, mode_next;
  logic [3:0] ctrl_reg, ctrl_next;
  logic [2:0] pd_reg, pd_next;
  logic [15:0] lock_reg, lock_next;
  logic aux_reg, aux_next;
  logic [3:0] seq_reg, seq_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [1:0] seq_val;
  logic [1:0] seq_exp;
  logic wake_light;
  logic wake_deep;
  logic wake_stop;
  logic wake;

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  // Read data is latched in the setup cycle so it stands through the access
  assign rd_en = psel && !penable && !pwrite;

  // Decode of the mapped offsets; anything else draws an error
  always_comb begin
    unique case (paddr)
      EMC_OFS_CTRL,
      EMC_OFS_RAMPWR,
      EMC_OFS_LOCK,
      EMC_OFS_AUX,
      EMC_OFS_STATUS: begin
        addr_ok = 1'b1;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  assign pslverr = psel && penable && !addr_ok;
  assign prdata = rdata_reg;
  assign seq_val = pwdata[EMC_CTRL_SEQ_LSB +: 2];
  assign seq_exp = seq_reg[0] ? EMC_SEQ_B : EMC_SEQ_A;

  // Wake qualification per mode
  always_comb begin
    // Light sleep keeps the fast clock trees, so any enabled source counts
    wake_light = |wake_src || pin_irq; // [RULE_03] [RULE_05]
    // Only the slow domain and the asynchronous paths are alive here
    wake_deep = wake_src[EMC_W_RTC] ||
                wake_src[EMC_W_LOW_ENERGY_TIMER] ||
                wake_src[EMC_W_LCD] ||
                wake_src[EMC_W_PULSE_COUNTER] ||
                wake_src[EMC_W_LOW_ENERGY_UART] ||
                wake_src[EMC_W_I2C_ADDR] ||
                wake_src[EMC_W_CMP] ||
                pin_irq; // [RULE_04] [RULE_05]
    // The pulse counter only runs here when fed from outside
    wake_stop = wake_src[EMC_W_I2C_ADDR] ||
                wake_src[EMC_W_CMP] ||
                pin_irq ||
                (wake_src[EMC_W_PULSE_COUNTER] && pulse_counter_ext_clk); // [RULE_05] [RULE_06]
    unique case (mode_reg)
      EMC_LIGHT: begin
        wake = wake_light;
      end
      EMC_DEEP: begin
        wake = wake_deep;
      end
      EMC_STOP: begin
        wake = wake_stop;
      end
      default: begin
        // Active needs no wake and shutoff ignores every source
        wake = 1'b0; // [RULE_07]
      end
    endcase
  end

  // Register writes
  always_comb begin
    ctrl_next = ctrl_reg;
    pd_next = pd_reg;
    lock_next = lock_reg;
    aux_next = aux_reg;
    if (wr_en) begin
      unique case (paddr)
        EMC_OFS_CTRL: begin
          // Upper bits have no function and are not stored [RULE_14]
          ctrl_next = pwdata[3:0];
        end
        EMC_OFS_RAMPWR: begin
          // Powered-off bits only accumulate until reset [RULE_08] [RULE_09]
          pd_next = pd_reg | pwdata[2:0];
        end
        EMC_OFS_LOCK: begin
          // Key is only stored; locking of the other registers is not enforced
          lock_next = pwdata[15:0];
        end
        EMC_OFS_AUX: begin
          aux_next = pwdata[0];
        end
        default: begin
          // Unmapped offsets answer with an error and change nothing
        end
      endcase
    end
  end

  // Shutoff entry sequence tracking
  always_comb begin
    seq_next = seq_reg;
    if (wr_en && paddr == EMC_OFS_CTRL) begin
      if (seq_val == 2'h0) begin
        seq_next = 4'h0; // [RULE_16]
      end else if (seq_val == seq_exp) begin
        seq_next = seq_reg + 4'h1; // [RULE_15]
      end else begin
        // Restart, keeping a stray 2 as a fresh first step [RULE_19]
        seq_next = (seq_val == EMC_SEQ_A) ? 4'h1 : 4'h0;
      end
    end
  end

  // Energy mode sequencing
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      EMC_ACTIVE: begin
        if (wr_en && paddr == EMC_OFS_CTRL && seq_val == EMC_SEQ_A &&
            seq_reg == EMC_SEQ_LAST) begin
          mode_next = EMC_SHUTOFF; // [RULE_11]
        end else if (sleep_req) begin
          if (!sleep_deep || ctrl_reg[EMC_CTRL_BLOCK_BIT]) begin
            mode_next = EMC_LIGHT; // [RULE_12] [RULE_17]
          end else begin
            mode_next = EMC_DEEP;
          end
        end
      end
      EMC_LIGHT, EMC_DEEP, EMC_STOP: begin
        if (wake) begin
          mode_next = EMC_ACTIVE; // [RULE_01]
        end
      end
      EMC_SHUTOFF: begin
        // Only the asynchronous reset leaves shutoff
        mode_next = EMC_SHUTOFF; // [RULE_07]
      end
      default: begin
        // An upset code recovers to active rather than hanging
        mode_next = EMC_ACTIVE;
      end
    endcase
  end

  // Read data captured in the setup cycle
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_en) begin
      unique case (paddr)
        EMC_OFS_CTRL: begin
          rdata_next = {28'h0000000, ctrl_reg};
        end
        EMC_OFS_RAMPWR: begin
          rdata_next = {29'h00000000, pd_reg};
        end
        EMC_OFS_LOCK: begin
          rdata_next = {31'h00000000, lock_reg != 16'h0000};
        end
        EMC_OFS_AUX: begin
          rdata_next = {31'h00000000, aux_reg};
        end
        EMC_OFS_STATUS: begin
          rdata_next = {25'h0000000, seq_reg, mode_reg};
        end
        default: begin
          rdata_next = 32'h00000000;
        end
      endcase
    end
  end

  // Any reset returns to active mode, whatever mode it finds [RULE_02]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= EMC_ACTIVE;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Reset is the only way to power a RAM block up again [RULE_09]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= EMC_CTRL_RESET[3:0];
      pd_reg <= 3'h0;
      lock_reg <= EMC_LOCK_RESET;
      aux_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      pd_reg <= pd_next;
      lock_reg <= lock_next;
      aux_reg <= aux_next;
    end
  end

  // A reset in mid-sequence discards the partial shutoff request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_reg <= 4'h0;
    end else begin
      seq_reg <= seq_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign mode = mode_reg;

  // Drive applies in deep sleep and stop only; elsewhere the regulator is full [RULE_13]
  always_comb begin
    reg_full_drive = 1'b1;
    if ((mode_reg == EMC_DEEP) || (mode_reg == EMC_STOP)) begin
      reg_full_drive = ctrl_reg[EMC_CTRL_DRIVE_BIT];
    end
  end

  // Block 0 has no off control at all [RULE_10] [RULE_18]
  always_comb begin
    ram_block_on = 4'hF;
    if (pd_reg[2]) begin
      // Any code with the top bit set removes block 3
      ram_block_on[3] = 1'b0;
    end
    if (pd_reg == EMC_PD_BLK23 || pd_reg == EMC_PD_BLK123) begin
      ram_block_on[2] = 1'b0;
    end
    if (pd_reg == EMC_PD_BLK123) begin
      ram_block_on[1] = 1'b0;
    end
  end
endmodule

// ==== emc_core_model.sv ====
module emc_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench requests
  input wire logic go,
  input wire logic deep,
  // Core sleep outputs
  output logic sleep_req,
  output logic sleep_deep
);
  timeunit 1ns;
  timeprecision 1ns;
  // Registered copy of go, one cycle late; a one-cycle go gives a one-cycle pulse, as a sleep instruction does
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleep_req <= 1'b0;
      sleep_deep <= 1'b0;
    end else begin
      sleep_req <= go;
      sleep_deep <= deep;
    end
  end
endmodule

// ==== emc_checker.sv ====
module emc_checker
  import emc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Core and wake inputs
  input wire logic sleep_req,
  input wire logic sleep_deep,
  input wire logic [emc_pkg::EMC_SRC_W-1:0] wake_src,
  input wire logic pin_irq,
  // Watched outputs
  input wire emc_pkg::emc_mode_t mode,
  input wire logic reg_full_drive,
  input wire logic [3:0] ram_block_on
);
  // Sources still alive in deep sleep
  localparam logic [16:0] LE_MASK = 17'h1C0A9;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_light_wake: assert property (mode == EMC_LIGHT && (|wake_src) |=> mode == EMC_ACTIVE)
    else $error("light sleep did not wake");
  chk_deep_ignore: assert property (mode == EMC_DEEP && !pin_irq && !(|(wake_src & LE_MASK))
    |=> mode == EMC_DEEP) else $error("deep sleep woke on fast source");
  chk_deep_wake: assert property (mode == EMC_DEEP && (pin_irq || |(wake_src & LE_MASK))
    |=> mode == EMC_ACTIVE) else $error("deep sleep missed wake");
  chk_shutoff_hold: assert property (mode == EMC_SHUTOFF |=> mode == EMC_SHUTOFF)
    else $error("left shutoff without reset");
  chk_first_block: assert property (ram_block_on[0])
    else $error("first ram block unpowered");
  chk_block_sticky: assert property (1'b1 |=> (ram_block_on & ~$past(ram_block_on)) == 4'h0)
    else $error("ram block powered again");
  chk_drive_active: assert property (mode != EMC_DEEP && mode != EMC_STOP |-> reg_full_drive)
    else $error("drive reduced outside deep sleep");
  chk_light_enter: assert property (sleep_req && !sleep_deep && mode == EMC_ACTIVE && !pin_irq
    && !(|wake_src) |=> mode == EMC_LIGHT) else $error("light sleep not entered");
  cover property (mode == EMC_SHUTOFF);
  cover property (mode == EMC_DEEP);
  cover property (ram_block_on == 4'h1);
endmodule
bind emc_energy_mode_wakeup_control emc_checker chk_i (.clk(clk), .rst(rst),
  .sleep_req(sleep_req), .sleep_deep(sleep_deep), .wake_src(wake_src), .pin_irq(pin_irq),
  .mode(mode), .reg_full_drive(reg_full_drive), .ram_block_on(ram_block_on));

// ==== testbench.sv ====
module testbench
  import emc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic dp; logic [16:0] w; logic p; emc_mode_t e;} emc_row_t;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic go = 1'b0, deep = 1'b0, pin_irq = 1'b0, pulse_counter_ext_clk = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, serr, sleep_req, sleep_deep, reg_full_drive;
  logic [16:0] wake_src = 17'h00000;
  logic [3:0] ram_block_on;
  logic [1:0] sv [9] = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2};
  emc_mode_t mode;
  int n_errors = 0, checks_done = 0;
  emc_row_t rows [7] = '{'{1'b0, 17'h00040, 1'b0, EMC_ACTIVE}, '{1'b0, 17'h00010, 1'b0, EMC_ACTIVE},
    '{1'b1, 17'h00040, 1'b0, EMC_DEEP}, '{1'b1, 17'h00001, 1'b0, EMC_ACTIVE},
    '{1'b1, 17'h00020, 1'b0, EMC_ACTIVE}, '{1'b1, 17'h10000, 1'b0, EMC_ACTIVE},
    '{1'b1, 17'h00000, 1'b1, EMC_ACTIVE}};
  emc_energy_mode_wakeup_control uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_req(sleep_req), .sleep_deep(sleep_deep), .wake_src(wake_src),
    .pulse_counter_ext_clk(pulse_counter_ext_clk), .pin_irq(pin_irq), .mode(mode),
    .reg_full_drive(reg_full_drive), .ram_block_on(ram_block_on));
  emc_core_model core_i (.clk(clk), .rst(rst), .go(go), .deep(deep), .sleep_req(sleep_req),
    .sleep_deep(sleep_deep));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk) penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    serr = pslverr;
    {psel, penable} <= 2'b00;
    #1;
  endtask
  task automatic sleep(input logic dp);
    @(posedge clk) {go, deep} <= {1'b1, dp};
    @(posedge clk) go <= 1'b0;
    @(posedge clk) #1;
  endtask
  // Pin interrupt wakes every sleep mode but shutoff, so it is the common recovery
  task automatic wake(input logic [16:0] w, input logic p);
    @(posedge clk) {wake_src, pin_irq} <= {w, p};
    @(posedge clk) #1;
  endtask
  task automatic seq(input int a, input int b);
    for (int i = a; i < b; i++) apb(1'b1, EMC_OFS_CTRL, {28'h0, sv[i], 2'h0});
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    chk(mode, EMC_ACTIVE, "reset mode");
    chk(ram_block_on, 4'hF, "reset ram");
    apb(1'b0, EMC_OFS_CTRL, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    foreach (rows[i]) begin
      sleep(rows[i].dp);
      chk(mode, rows[i].dp ? EMC_DEEP : EMC_LIGHT, "sleep entry");
      wake(rows[i].w, rows[i].p);
      chk(mode, rows[i].e, "wake result");
      wake(17'h00000, 1'b1);
      wake(17'h00000, 1'b0);
    end
    sleep(1'b1);
    chk(reg_full_drive, 1'b0, "reduced drive");
    wake(17'h00000, 1'b1);
    apb(1'b1, EMC_OFS_CTRL, 32'hFFFF_FFF3);
    apb(1'b0, EMC_OFS_CTRL, 32'h0);
    chk(rd, 32'h3, "ctrl reserved");
    wake(17'h00000, 1'b0);
    sleep(1'b1);
    chk(mode, EMC_LIGHT, "blocked deep");
    wake(17'h00000, 1'b1);
    wake(17'h00000, 1'b0);
    apb(1'b0, 12'h010, 32'h0);
    chk({serr, rd}, {1'b1, 32'h0}, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, EMC_OFS_RAMPWR, {29'h0, i == 0 ? 3'h0 : i == 1 ? EMC_PD_BLK3 :
        i == 2 ? EMC_PD_BLK23 : EMC_PD_BLK123});
      chk(ram_block_on, 4'(i == 0 ? 4'hF : i == 1 ? 4'h7 : i == 2 ? 4'h3 : 4'h1), "ram");
    end
    apb(1'b1, EMC_OFS_RAMPWR, 32'h0);
    chk(ram_block_on, 4'h1, "ram sticky");
    seq(0, 5);
    apb(1'b1, EMC_OFS_CTRL, 32'h0);
    seq(5, 9);
    chk(mode, EMC_ACTIVE, "zero restarts");
    seq(0, 8);
    apb(1'b1, EMC_OFS_CTRL, 32'hC);
    chk(mode, EMC_ACTIVE, "wrong step");
    seq(0, 9);
    @(posedge clk) #1;
    chk(mode, EMC_SHUTOFF, "shutoff");
    wake(17'h1FFFF, 1'b1);
    chk(mode, EMC_SHUTOFF, "shutoff hold");
    rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    @(posedge clk) #1;
    chk({mode, ram_block_on}, {EMC_ACTIVE, 4'hF}, "reset exit");
    stop_test();
  end
endmodule
